// ===== hdl/vsp_port.sv
// Shared serial audio port: stereo word mode or slotted voice mode, master or slave.
`default_nettype none

// Overview of operation
// - Master drives bit clock and word select; slave receives them; data out, data in fixed.
// - Stereo words are 16 bits, 32-bit frame, left MSB first on the bus.
// - Word MSB goes out one bit after each word-select change, on falling edge.
// - Left word travels while word select is low, right word while high.
// - Data changes on falling bit-clock edges and is captured on rising edges.
// - Stereo master bit clock is 1411.2 kHz or 1536 kHz, or 24 MHz when burst is selected.
// - Stereo slave accepts any bit clock up to 3.072 MHz.
// - Voice and stereo modes share one engine; only one runs at a time.
// - Voice master makes bit clock and sync; voice slave takes both as inputs.
// - Voice samples flow both ways at once; reset default is stereo mode.
// - Up to three full-duplex voice channels share up to 16 slots.
// - Rates 128 to 2048 kHz give 1, 2, 4, 8, 16 slots.
// - Each channel sends and receives in the same slot.
// - Data out floats in unused slots, released at falling edge ending own slot.
// - Short sync is a one-bit high pulse aligned to a rising edge.
// - Short-sync slave sees sync high on falling edge; slot zero follows.
// - Long sync is high three bits, starting with first bit of slot zero.
// - Voice words carry 13 significant bits with configurable position and order.
// - Spare bits ignored on receive; sent as zeros, ones, sign or value.
// - Default format: 13-bit, left justified, zero fill, MSB first.
// - Burst selection runs the bit clock at up to 24 MHz.
// - Short or long sync is selectable in master and slave roles.

module vsp_port (
    input  wire logic                clock_in,
    input  wire logic                resetn_in,
    input  wire vsp_pkg::vsp_cfg_t   cfg_in,
    input  wire logic                enable_in,
    input  wire vsp_pkg::vsp_words_t tx_sample_in,
    output logic                     busy_out,
    output logic                     frame_strobe_out,
    output vsp_pkg::vsp_words_t      rx_sample_out,
    input  wire logic                sck_in,
    output logic                     sck_out,
    output logic                     sck_oe_n_out,
    input  wire logic                ws_in,
    output logic                     ws_out,
    output logic                     ws_oe_n_out,
    input  wire logic                di_in,
    output logic                     do_out,
    output logic                     do_oe_n_out
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic [1:0] lrst_sync_q;
    logic       rst_n;
    logic       lrst_n;

    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end

    assign rst_n = rst_sync_q[1];

    // The link side only leaves reset once its own clock has ticked twice.
    always_ff @(posedge sck_in or negedge rst_n)
    begin
        if (!rst_n)
            lrst_sync_q <= 2'h0;
        else
            lrst_sync_q <= {lrst_sync_q[0], 1'b1};
    end

    assign lrst_n = lrst_sync_q[1];

    vsp_pkg::vsp_sys_t  s_q;
    vsp_pkg::vsp_sys_t  s_d;
    vsp_pkg::vsp_lpos_t lp_q;
    vsp_pkg::vsp_lpos_t lp_d;
    vsp_pkg::vsp_lneg_t ln_q;
    vsp_pkg::vsp_lneg_t ln_d;

    // ------------------------------------------------------------------
    // System clock side
    // ------------------------------------------------------------------
    always_comb
    begin
        logic                       run;
        logic                       carry;
        logic [vsp_pkg::NCO_W-1:0]  sum;
        run   = 1'b0;
        carry = 1'b0;
        sum   = '0;
        s_d   = s_q;
        s_d.en      = enable_in;
        s_d.busy_s1 = lp_q.en_s2;
        s_d.busy_s2 = s_q.busy_s1;
        s_d.tgl_s1  = lp_q.tgl;
        s_d.tgl_s2  = s_q.tgl_s1;
        s_d.tgl_s3  = s_q.tgl_s2;
        s_d.strobe  = 1'b0;
        // Settings move only when both domains agree the port is stopped.
        if (!s_q.en && !s_q.busy_s2)
            s_d.cfg = cfg_in;
        s_d.sck_oe_n = !s_q.cfg.master;
        s_d.ws_oe_n  = !s_q.cfg.master;
        // Fractional divider; edges jitter by one system clock.
        run = s_q.cfg.master && (s_q.en || s_q.busy_s2);
        {carry, sum} = {1'b0, s_q.acc} + {1'b0, vsp_pkg::nco_inc(s_q.cfg)};
        if (run)
        begin
            s_d.acc = sum;
            if (carry)
                s_d.sck = !s_q.sck;
        end
        else
        begin
            s_d.acc = '0;
            s_d.sck = 1'b0;
        end
        // Mid-frame event: words are exchanged half a frame away from their use.
        if (s_q.tgl_s2 != s_q.tgl_s3)
        begin
            s_d.strobe = 1'b1;
            for (int c = 0; c < vsp_pkg::N_CH; c++)
            begin
                if (s_q.cfg.pcm)
                begin
                    s_d.tx_hold[c] = vsp_pkg::fmt_tx(s_q.cfg, tx_sample_in[c]);
                    s_d.rx_out[c]  = vsp_pkg::unfmt_rx(s_q.cfg, lp_q.rx_hold[c]);
                end
                else
                begin
                    s_d.tx_hold[c] = tx_sample_in[c];
                    s_d.rx_out[c]  = lp_q.rx_hold[c];
                end
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_n)
    begin
        if (!rst_n)
            s_q <= vsp_pkg::SYS_RESET;
        else
            s_q <= s_d;
    end

    // ------------------------------------------------------------------
    // Link side, rising edge: framing, capture, sync generation
    // ------------------------------------------------------------------
    always_comb
    begin
        logic [vsp_pkg::POS_W-1:0] mask;
        logic [vsp_pkg::POS_W-1:0] half;
        logic [vsp_pkg::POS_W-1:0] eff;
        logic [vsp_pkg::POS_W-1:0] idx;
        logic [vsp_pkg::POS_W-1:0] nxt;
        mask = vsp_pkg::frame_mask(s_q.cfg);
        half = (mask >> 1) + 8'h01;
        eff  = lp_q.pos;
        idx  = '0;
        nxt  = '0;
        lp_d = lp_q;
        lp_d.en_s1   = s_q.en;
        lp_d.en_s2   = lp_q.en_s1;
        lp_d.ws_prev = ws_in;
        if (!lp_q.en_s2)
        begin
            lp_d.pos  = '0;
            lp_d.ws_o = 1'b0;
        end
        else
        begin
            if (!s_q.cfg.master)
            begin
                if (!s_q.cfg.pcm && !ws_in && lp_q.ws_prev)
                    eff = '0;
                else if (s_q.cfg.pcm && !s_q.cfg.long_sync && ln_q.sync_fall)
                    eff = '0;
                else if (s_q.cfg.pcm && s_q.cfg.long_sync && ws_in && !lp_q.ws_prev)
                    eff = 8'h01;
            end
            idx = (eff - 8'h01) & mask;
            for (int c = 0; c < vsp_pkg::N_CH; c++)
            begin
                if (vsp_pkg::slot_hit(s_q.cfg, c, idx[7:4]))
                    lp_d.rxsh[c][~idx[3:0]] = di_in;
            end
            if (eff == '0)
                lp_d.rx_hold = lp_d.rxsh;
            if (eff == half)
                lp_d.tgl = !lp_q.tgl;
            nxt = (eff + 8'h01) & mask;
            lp_d.pos = nxt;
            if (!s_q.cfg.pcm)
                lp_d.ws_o = (nxt >= vsp_pkg::I2S_HALF);
            else if (!s_q.cfg.long_sync)
                lp_d.ws_o = (nxt == '0);
            else
                lp_d.ws_o = (nxt != '0) && (nxt <= vsp_pkg::LONG_SYNC_END);
        end
    end

    always_ff @(posedge sck_in or negedge lrst_n)
    begin
        if (!lrst_n)
            lp_q <= vsp_pkg::LPOS_RESET;
        else
            lp_q <= lp_d;
    end

    // ------------------------------------------------------------------
    // Link side, falling edge: data launch and slave sync sampling
    // ------------------------------------------------------------------
    // Transmit words come from the system side; they were settled half a frame earlier.
    always_comb
    begin
        logic [vsp_pkg::POS_W-1:0] idx;
        vsp_pkg::vsp_words_t       words;
        idx   = (lp_q.pos - 8'h01) & vsp_pkg::frame_mask(s_q.cfg);
        words = (lp_q.pos == 8'h01) ? s_q.tx_hold : ln_q.cur;
        ln_d  = ln_q;
        ln_d.sync_fall = ws_in;
        ln_d.cur       = words;
        ln_d.dout      = 1'b0;
        ln_d.dout_oe_n = s_q.cfg.pcm;
        if (lp_q.en_s2)
        begin
            for (int c = 0; c < vsp_pkg::N_CH; c++)
            begin
                if (vsp_pkg::slot_hit(s_q.cfg, c, idx[7:4]))
                begin
                    ln_d.dout      = words[c][~idx[3:0]];
                    ln_d.dout_oe_n = 1'b0;
                end
            end
            if (!s_q.cfg.pcm)
                ln_d.dout_oe_n = 1'b0;
        end
        // Unused slots float so other devices can share the data line.
        if (s_q.cfg.pcm && ln_d.dout_oe_n)
            ln_d.dout = 1'b0;
    end

    always_ff @(negedge sck_in or negedge lrst_n)
    begin
        if (!lrst_n)
            ln_q <= vsp_pkg::LNEG_RESET;
        else
            ln_q <= ln_d;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign busy_out         = s_q.busy_s2;
    assign frame_strobe_out = s_q.strobe;
    assign rx_sample_out    = s_q.rx_out;
    assign sck_out          = s_q.sck;
    assign sck_oe_n_out     = s_q.sck_oe_n;
    assign ws_out           = lp_q.ws_o;
    assign ws_oe_n_out      = s_q.ws_oe_n;
    assign do_out           = ln_q.dout;
    assign do_oe_n_out      = ln_q.dout_oe_n;

endmodule

`default_nettype wire

// ===== hdl/vsp_pkg.sv
// Package for the shared voice and audio serial port: constants, types and helpers.
`default_nettype none

package vsp_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int N_CH           = 3;
    localparam int WORD_BITS      = 16;
    localparam int SAMPLE_BITS    = 13;
    localparam int I2S_FRAME_BITS = 32;
    localparam int SLOT_BITS      = 16;
    localparam int MAX_SLOTS      = 16;
    localparam int LONG_SYNC_BITS = 3;
    localparam int POS_W          = 8;
    localparam int NCO_W          = 32;

    localparam logic [2:0]       MAX_RATE_SEL  = 3'h4;
    localparam logic [POS_W-1:0] I2S_MASK      = 8'h1F;
    localparam logic [POS_W-1:0] I2S_HALF      = 8'h10;
    localparam logic [POS_W-1:0] SLOT_BASE_LEN = 8'h10;
    localparam logic [POS_W-1:0] LONG_SYNC_END = 8'h03;

    // ------------------------------------------------------------------
    // Rates
    // ------------------------------------------------------------------
    localparam longint unsigned CLK_HZ       = 100_000_000;
    localparam longint unsigned I2S_441_HZ   = 1_411_200;
    localparam longint unsigned I2S_48_HZ    = 1_536_000;
    localparam longint unsigned PCM_BASE_HZ  = 128_000;
    localparam longint unsigned BURST_HZ     = 24_000_000;
    localparam longint unsigned SLAVE_MAX_HZ = 3_072_000;
    localparam longint unsigned NCO_SCALE    = 64'h0000_0001_0000_0000;

    // The accumulator toggles the bit clock on each carry, so it adds twice the bit rate.
    localparam logic [NCO_W-1:0] INC_I2S_441 = 32'((2 * I2S_441_HZ * NCO_SCALE) / CLK_HZ);
    localparam logic [NCO_W-1:0] INC_I2S_48  = 32'((2 * I2S_48_HZ * NCO_SCALE) / CLK_HZ);
    localparam logic [NCO_W-1:0] INC_PCM     = 32'((2 * PCM_BASE_HZ * NCO_SCALE) / CLK_HZ);
    localparam logic [NCO_W-1:0] INC_BURST   = 32'((2 * BURST_HZ * NCO_SCALE) / CLK_HZ);

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {FILL_ZERO, FILL_ONE, FILL_SIGN, FILL_PROG} vsp_fill_t;

    typedef logic [N_CH-1:0][WORD_BITS-1:0] vsp_words_t;

    typedef struct packed {
        logic                 master;
        logic                 pcm;
        logic [2:0]           rate_sel;
        logic                 burst;
        logic                 long_sync;
        logic                 i2s_48k;
        logic                 right_just;
        logic                 lsb_first;
        vsp_fill_t            fill;
        logic [2:0]           fill_val;
        logic [N_CH-1:0]      ch_en;
        logic [N_CH-1:0][3:0] ch_slot;
    } vsp_cfg_t;

    typedef struct packed {
        vsp_cfg_t         cfg;
        logic             en;
        logic             busy_s1;
        logic             busy_s2;
        logic             tgl_s1;
        logic             tgl_s2;
        logic             tgl_s3;
        logic             strobe;
        logic [NCO_W-1:0] acc;
        logic             sck;
        logic             sck_oe_n;
        logic             ws_oe_n;
        vsp_words_t       tx_hold;
        vsp_words_t       rx_out;
    } vsp_sys_t;

    typedef struct packed {
        logic             en_s1;
        logic             en_s2;
        logic             ws_prev;
        logic             ws_o;
        logic             tgl;
        logic [POS_W-1:0] pos;
        vsp_words_t       rxsh;
        vsp_words_t       rx_hold;
    } vsp_lpos_t;

    typedef struct packed {
        logic       sync_fall;
        logic       dout;
        logic       dout_oe_n;
        vsp_words_t cur;
    } vsp_lneg_t;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam vsp_cfg_t CFG_RESET = '{
        master: 1'b0, pcm: 1'b0, rate_sel: 3'h0, burst: 1'b0, long_sync: 1'b0,
        i2s_48k: 1'b0, right_just: 1'b0, lsb_first: 1'b0, fill: FILL_ZERO,
        fill_val: 3'h0, ch_en: 3'h0, ch_slot: 12'h000};
    localparam vsp_sys_t  SYS_RESET  = '{cfg: CFG_RESET, sck_oe_n: 1'b1, ws_oe_n: 1'b1,
                                         default: '0};
    localparam vsp_lpos_t LPOS_RESET = '{default: '0};
    localparam vsp_lneg_t LNEG_RESET = '{default: '0};

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [POS_W-1:0] frame_mask(input vsp_cfg_t c);
        logic [2:0] r;
        r = (c.rate_sel > MAX_RATE_SEL) ? MAX_RATE_SEL : c.rate_sel;
        return c.pcm ? 8'((9'(SLOT_BASE_LEN) << r) - 9'h001) : I2S_MASK;
    endfunction

    function automatic logic slot_hit(input vsp_cfg_t c, input int ch, input logic [3:0] s);
        if (!c.pcm)
            return (ch < 2) && (s == 4'(ch));
        return c.ch_en[ch] && (c.ch_slot[ch] == s);
    endfunction

    function automatic logic [WORD_BITS-1:0] rev16(input logic [WORD_BITS-1:0] w);
        logic [WORD_BITS-1:0] r;
        r = '0;
        for (int i = 0; i < WORD_BITS; i++)
            r[i] = w[WORD_BITS-1-i];
        return r;
    endfunction

    function automatic logic [WORD_BITS-1:0] fmt_tx(input vsp_cfg_t c,
                                                     input logic [WORD_BITS-1:0] s);
        logic [2:0]           f;
        logic [WORD_BITS-1:0] w;
        unique case (c.fill)
            FILL_ZERO: f = 3'h0;
            FILL_ONE:  f = 3'h7;
            FILL_SIGN: f = {3{s[SAMPLE_BITS-1]}};
            FILL_PROG: f = c.fill_val;
        endcase
        w = c.right_just ? {f, s[SAMPLE_BITS-1:0]} : {s[SAMPLE_BITS-1:0], f};
        return c.lsb_first ? rev16(w) : w;
    endfunction

    function automatic logic [WORD_BITS-1:0] unfmt_rx(input vsp_cfg_t c,
                                                       input logic [WORD_BITS-1:0] w);
        logic [WORD_BITS-1:0]   o;
        logic [SAMPLE_BITS-1:0] v;
        o = c.lsb_first ? rev16(w) : w;
        v = c.right_just ? o[SAMPLE_BITS-1:0] : o[WORD_BITS-1:WORD_BITS-SAMPLE_BITS];
        return {{3{v[SAMPLE_BITS-1]}}, v};
    endfunction

    function automatic logic [NCO_W-1:0] nco_inc(input vsp_cfg_t c);
        logic [2:0] r;
        r = (c.rate_sel > MAX_RATE_SEL) ? MAX_RATE_SEL : c.rate_sel;
        if (c.burst)
            return INC_BURST;
        if (c.pcm)
            return INC_PCM << r;
        return c.i2s_48k ? INC_I2S_48 : INC_I2S_441;
    endfunction

endpackage

`default_nettype wire

// ===== tb/vsp_port_asserts.sv
// Concurrent checks on the serial audio port's outputs.
`default_nettype none

module vsp_port_asserts (
    input wire logic                clock_in,
    input wire logic                resetn_in,
    input wire vsp_pkg::vsp_cfg_t   cfg_in,
    input wire logic                enable_in,
    input wire logic                busy_out,
    input wire logic                frame_strobe_out,
    input wire vsp_pkg::vsp_words_t rx_sample_out,
    input wire logic                sck_in,
    input wire logic                sck_out,
    input wire logic                sck_oe_n_out,
    input wire logic                ws_out,
    input wire logic                ws_oe_n_out,
    input wire logic                do_out,
    input wire logic                do_oe_n_out
);
    // --------
    // Half-period counter
    // --------
    logic [15:0] hp_q;
    wire logic   run = busy_out && enable_in;

    // The accumulator allows one system clock of jitter, so two counts pass.
    function automatic int half_f(input vsp_pkg::vsp_cfg_t c);
        if (c.burst)
            return 2;
        if (c.pcm)
            return (390625 >> ((c.rate_sel > 3'h4) ? 3'h4 : c.rate_sel)) / 1000;
        return c.i2s_48k ? 32 : 35;
    endfunction

    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
            hp_q <= 16'h0000;
        else
            hp_q <= $changed(sck_out) ? 16'h0000 : hp_q + 16'h0001;
    end

    // --------
    // Checks
    // --------
    sequence s_long;
        ws_out [*3] ##1 !ws_out;
    endsequence

    AST_RATE: assert property (@(posedge clock_in) disable iff (!resetn_in)
        run && !sck_oe_n_out && $changed(sck_out) |->
        int'(hp_q) >= half_f(cfg_in) - 1 && int'(hp_q) <= half_f(cfg_in))
        else $error("bit clock half period wrong");
    AST_RX_STROBE: assert property (@(posedge clock_in) disable iff (!resetn_in)
        $changed(rx_sample_out) |-> frame_strobe_out)
        else $error("rx moved without strobe");
    AST_STROBE_ONE: assert property (@(posedge clock_in) disable iff (!resetn_in)
        frame_strobe_out |=> !frame_strobe_out)
        else $error("strobe too long");
    AST_BUSY_CAUSE: assert property (@(posedge clock_in) disable iff (!resetn_in)
        $changed(busy_out) |-> busy_out == enable_in)
        else $error("busy moved against enable");
    AST_ROLE: assert property (@(posedge clock_in) disable iff (!resetn_in)
        busy_out |-> sck_oe_n_out == !cfg_in.master && ws_oe_n_out == sck_oe_n_out)
        else $error("pin drive wrong for role");
    AST_DO_STEREO: assert property (@(posedge clock_in) disable iff (!resetn_in)
        run && !cfg_in.pcm |-> !do_oe_n_out)
        else $error("data out released in stereo mode");
    AST_DO_EDGE: assert property (@(posedge clock_in) disable iff (!resetn_in)
        run && $changed(do_out) |-> !sck_in)
        else $error("data out moved off falling edge");
    AST_OE_EDGE: assert property (@(posedge clock_in) disable iff (!resetn_in)
        run && $changed(do_oe_n_out) |-> !sck_in)
        else $error("data release off falling edge");
    AST_WS_EDGE: assert property (@(posedge clock_in) disable iff (!resetn_in)
        run && !ws_oe_n_out && $changed(ws_out) |-> sck_in)
        else $error("sync moved off rising edge");
    AST_SHORT_SYNC: assert property (@(posedge sck_in) disable iff (!resetn_in)
        run && cfg_in.pcm && !cfg_in.long_sync && !ws_oe_n_out && $rose(ws_out)
        |=> !ws_out)
        else $error("short sync not one bit");
    AST_LONG_SYNC: assert property (@(posedge sck_in) disable iff (!resetn_in)
        run && cfg_in.pcm && cfg_in.long_sync && !ws_oe_n_out && $rose(ws_out) |-> s_long)
        else $error("long sync not three bits");
endmodule

bind vsp_port vsp_port_asserts u_chk (.*);

`default_nettype wire

// ===== tb/vsp_codec_model.sv
// Far-side codec model: bit clock, sync and frame data.
`default_nettype none

module vsp_codec_model (
    input  wire logic        gen_in,
    input  wire logic [1:0]  mode_in,
    input  wire logic [31:0] word_in,
    input  wire logic        sck_in,
    input  wire logic        do_in,
    input  wire logic        do_oe_n_in,
    output logic             sck_out,
    output logic             ws_out,
    output logic             di_out,
    output logic [31:0]      cap_out,
    output logic [31:0]      oe_cap_out,
    output logic [7:0]       frames_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // --------
    // Frame engine
    // --------
    logic       clk_q = 1'b0;
    logic       di_q  = 1'b0;
    logic [4:0] b_q   = 5'h00;
    logic [4:0] nb;

    // The clock stands low between runs.
    initial
    begin
        ws_out = 1'b0;
        frames_out = 8'h00;
        #37;
        forever
            #80 clk_q = gen_in & ~clk_q;
    end

    assign sck_out = clk_q;
    assign di_out  = gen_in ? di_q : ~di_q;
    assign nb      = b_q + 5'h01;

    always @(negedge sck_in)
    begin
        b_q  <= nb;
        di_q <= word_in[5'h1F - nb];
        if (mode_in == 2'h0)
            ws_out <= nb >= 5'h0F && nb <= 5'h1E;
        if (mode_in == 2'h2)
            ws_out <= nb < 5'h03;
    end

    always @(posedge sck_in)
    begin
        cap_out[5'h1F - b_q]    <= do_in;
        oe_cap_out[5'h1F - b_q] <= do_oe_n_in;
        if (mode_in == 2'h1)
            ws_out <= b_q == 5'h1E;
        if (b_q == 5'h1F)
            frames_out <= frames_out + 8'h01;
    end
endmodule

`default_nettype wire

// ===== tb/test_vsp_port.sv
// Self-checking bench for the shared serial audio port.
`default_nettype none
`define CHK(a, b) chk_eq(64'(a), 64'(b))

module test_vsp_port;
    timeunit 1ns;
    timeprecision 1ps;

    logic                clock_in  = 1'b0;
    logic                resetn_in = 1'b0;
    logic                enable_in = 1'b0;
    vsp_pkg::vsp_cfg_t   cfg       = vsp_pkg::CFG_RESET;
    vsp_pkg::vsp_words_t txs       = '0;
    vsp_pkg::vsp_words_t rxs, exp_rx;
    logic                busy, strobe, d_sck, sck_oe_n, d_ws, ws_oe_n, d_do, do_oe_n;
    logic                p_sck, p_ws, p_di;
    logic                p_gen     = 1'b0;
    logic [1:0]          p_mode    = 2'h0;
    logic [31:0]         p_word    = '0;
    logic [31:0]         cap, ocap, exp_cap, exp_oe;
    logic [7:0]          frames;
    int                  error_cnt = 0;
    int                  checked   = 0;
    int                  seed      = 65;
    wire logic           sck_w     = sck_oe_n ? p_sck : d_sck;
    wire logic           ws_w      = ws_oe_n ? p_ws : d_ws;

    // --------
    // Helpers
    // --------
    task automatic chk_eq(input logic [63:0] a, input logic [63:0] b);
        checked++;
        if (a !== b)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, a, b);
        end
    endtask

    task automatic conclude();
        if (error_cnt == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    function automatic logic [15:0] fmt(input logic [15:0] s, input vsp_pkg::vsp_cfg_t c);
        logic [2:0]  f;
        logic [15:0] w;
        f = c.fill == vsp_pkg::FILL_ZERO ? 3'h0 : c.fill == vsp_pkg::FILL_ONE ? 3'h7 :
            c.fill == vsp_pkg::FILL_SIGN ? {3{s[12]}} : c.fill_val;
        w = c.right_just ? {f, s[12:0]} : {s[12:0], f};
        return c.lsb_first ? 16'({<<{w}}) : w;
    endfunction

    function automatic logic [15:0] unf(input logic [15:0] w, input vsp_pkg::vsp_cfg_t c);
        logic [15:0] o;
        o = c.lsb_first ? 16'({<<{w}}) : w;
        return c.right_just ? {{3{o[12]}}, o[12:0]} : {{3{o[15]}}, o[15:3]};
    endfunction

    task automatic wait_busy(input logic v);
        for (int n = 0; n < 30000 && busy !== v; n++)
            @(posedge clock_in);
        `CHK(busy, v);
    endtask

    task automatic strobes(input int k);
        for (int n = 0; n < 60000 && k > 0; n++)
        begin
            @(posedge clock_in);
            if (strobe === 1'b1)
                k--;
        end
        `CHK(k, 0);
    endtask

    // Settings land only while idle, so each run stops first.
    task automatic start(input vsp_pkg::vsp_cfg_t c, input logic g, input logic [1:0] m);
        @(posedge clock_in);
        enable_in <= 1'b0;
        wait_busy(1'b0);
        cfg <= c;
        p_gen <= g;
        p_mode <= m;
        p_word <= $random(seed);
        txs <= vsp_pkg::vsp_words_t'({$random(seed), $random(seed)});
        repeat (2) @(posedge clock_in);
        enable_in <= 1'b1;
        wait_busy(1'b1);
    endtask

    task automatic run_chk(input logic [2:0] m);
        strobes(3);
        repeat (3)
        begin
            strobes(1);
            for (int ch = 0; ch < 3; ch++)
                if (m[ch])
                    `CHK(rxs[ch], exp_rx[ch]);
            @(frames);
            #1;
            `CHK(cap | exp_oe, exp_cap | exp_oe);
            `CHK(ocap, exp_oe);
        end
    endtask

    // --------
    // Stimulus
    // --------
    initial
    begin
        forever
            #5 clock_in = ~clock_in;
    end

    initial
    begin
        #900_000;
        error_cnt++;
        conclude();
    end

    initial
    begin
        vsp_pkg::vsp_cfg_t c;
        real               f;
        real               t0;
        repeat (4) @(posedge clock_in);
        resetn_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        `CHK({busy, strobe, sck_oe_n, ws_oe_n, do_oe_n}, 5'h06);
        c = vsp_pkg::CFG_RESET;
        start(c, 1'b1, 2'h0);
        exp_rx = {16'h0000, p_word[15:0], p_word[31:16]};
        exp_cap = {txs[0], txs[1]};
        exp_oe = 32'h0000_0000;
        run_chk(3'h3);
        for (int i = 0; i < 4; i++)
        begin
            c = vsp_pkg::CFG_RESET;
            c.pcm = 1'b1;
            c.rate_sel = 3'h1;
            c.fill = vsp_pkg::vsp_fill_t'(i);
            c.fill_val = 3'($random(seed));
            c.long_sync = i[0];
            c.right_just = i[1];
            c.lsb_first = i[0] ^ i[1];
            c.ch_en = i[0] ? 3'h1 : 3'h3;
            c.ch_slot = 12'h001;
            start(c, 1'b1, i[0] ? 2'h2 : 2'h1);
            exp_rx = {16'h0000, unf(p_word[31:16], c), unf(p_word[15:0], c)};
            exp_cap = {i[0] ? 16'h0000 : fmt(txs[1], c), fmt(txs[0], c)};
            exp_oe = i[0] ? 32'hFFFF_0000 : 32'h0000_0000;
            run_chk(c.ch_en);
        end
        for (int j = 0; j < 9; j++)
        begin
            c = vsp_pkg::CFG_RESET;
            c.master = 1'b1;
            c.pcm = j > 1;
            c.i2s_48k = j == 1;
            c.rate_sel = (j > 1 && j < 7) ? 3'(j - 2) : 3'h1;
            c.burst = j > 6;
            c.long_sync = j == 7;
            c.ch_en = 3'h1;
            start(c, 1'b0, 2'h0);
            f = !c.pcm ? (c.i2s_48k ? 1536000.0 : 1411200.0) :
                c.burst ? 24.0e6 : 128000.0 * (1 << c.rate_sel);
            @(posedge d_sck);
            t0 = $realtime;
            repeat (8) @(posedge d_sck);
            t0 = $realtime - t0 - 8.0e9 / f;
            `CHK(t0 > -20.0 && t0 < 20.0, 1'b1);
            `CHK({sck_oe_n, ws_oe_n}, 2'h0);
            if (c.burst)
                strobes(4);
        end
        conclude();
    end

    vsp_port u_dut (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .cfg_in(cfg),
        .enable_in(enable_in),
        .tx_sample_in(txs),
        .busy_out(busy),
        .frame_strobe_out(strobe),
        .rx_sample_out(rxs),
        .sck_in(sck_w),
        .sck_out(d_sck),
        .sck_oe_n_out(sck_oe_n),
        .ws_in(ws_w),
        .ws_out(d_ws),
        .ws_oe_n_out(ws_oe_n),
        .di_in(p_di),
        .do_out(d_do),
        .do_oe_n_out(do_oe_n)
    );

    vsp_codec_model u_codec (
        .gen_in(p_gen),
        .mode_in(p_mode),
        .word_in(p_word),
        .sck_in(sck_w),
        .do_in(d_do),
        .do_oe_n_in(do_oe_n),
        .sck_out(p_sck),
        .ws_out(p_ws),
        .di_out(p_di),
        .cap_out(cap),
        .oe_cap_out(ocap),
        .frames_out(frames)
    );
endmodule

`default_nettype wire
